// ===== logic/scb_pkg.sv
// Constants, types and decode functions of the system clock select and boot block.
// Assumes one pclk domain at 40 MHz and oscillators that arrive as free running pins.
package scb_pkg;

	// ****************************************************************
	// Register map
	// ****************************************************************
	localparam logic [7:0] SCB_ADDR_CLKMD  = 8'h00;
	localparam logic [7:0] SCB_ADDR_XTAL   = 8'h04;
	localparam logic [7:0] SCB_ADDR_TRIM   = 8'h08;
	localparam logic [7:0] SCB_ADDR_STATUS = 8'h0c;
	localparam logic [7:0] SCB_ADDR_CALRES = 8'h10;

	localparam logic [7:0] SCB_CLKMD_RST = 8'hf4;
	localparam logic [7:0] SCB_XTAL_RST  = 8'h00;
	localparam logic [7:0] SCB_TRIM_RST  = 8'h80;

	localparam int SCB_CLKMD_FAST_EN = 4;
	localparam int SCB_CLKMD_SLOW_EN = 2;
	localparam int SCB_XTAL_EN       = 7;
	localparam int SCB_XTAL_DRV_LSB  = 5;

	localparam int SCB_ST_RUN      = 0;
	localparam int SCB_ST_CAL_BUSY = 1;
	localparam int SCB_ST_CAL_DONE = 2;
	localparam int SCB_ST_CAL_ERR  = 3;
	localparam int SCB_ST_SRC_LSB  = 4;
	localparam int SCB_ST_DIV_LSB  = 6;

	// ****************************************************************
	// Timing
	// ****************************************************************
	localparam int SCB_BOOT_FAST_CYC   = 45;
	localparam int SCB_BOOT_NORMAL_CYC = 3000;
	localparam int SCB_CLK_MHZ         = 40;
	localparam int SCB_CAL_WINDOW_US   = 100;
	localparam int SCB_CAL_WINDOW_CYC  = SCB_CAL_WINDOW_US * SCB_CLK_MHZ;

	localparam logic [4:0] SCB_TARGET_DEF_MHZ = 5'h10;
	localparam logic [4:0] SCB_TARGET_MIN_MHZ = 5'h10;
	localparam logic [4:0] SCB_TARGET_MAX_MHZ = 5'h12;
	localparam logic [5:0] SCB_VDD_MIN_DV     = 6'h12;
	localparam logic [5:0] SCB_VDD_MAX_DV     = 6'h37;

	// ****************************************************************
	// Clock mode values left by calibration
	// ****************************************************************
	localparam logic [7:0] SCB_MODE_DIV2  = 8'h34;
	localparam logic [7:0] SCB_MODE_DIV4  = 8'h14;
	localparam logic [7:0] SCB_MODE_DIV8  = 8'h3c;
	localparam logic [7:0] SCB_MODE_DIV16 = 8'h1c;
	localparam logic [7:0] SCB_MODE_DIV32 = 8'h7c;
	localparam logic [7:0] SCB_MODE_SLOW  = 8'he4;

	// ****************************************************************
	// Types
	// ****************************************************************
	typedef enum logic [1:0] {
		SCB_SRC_FAST = 2'b00,
		SCB_SRC_SLOW = 2'b01,
		SCB_SRC_XTAL = 2'b10
	} scb_src_e;

	typedef enum logic [2:0] {
		SCB_CAL_DIV2  = 3'b000,
		SCB_CAL_DIV4  = 3'b001,
		SCB_CAL_DIV8  = 3'b010,
		SCB_CAL_DIV16 = 3'b011,
		SCB_CAL_DIV32 = 3'b100,
		SCB_CAL_SLOW  = 3'b101,
		SCB_CAL_OFF   = 3'b110
	} scb_cal_e;

	typedef enum logic [1:0] {
		SCB_BOOT_DELAY = 2'b00,
		SCB_BOOT_CAL   = 2'b01,
		SCB_BOOT_APPLY = 2'b10,
		SCB_BOOT_RUN   = 2'b11
	} scb_boot_e;

	typedef struct packed {
		logic     valid;
		scb_src_e src;
		logic [2:0] div_exp;
	} scb_sel_s;

	typedef struct packed {
		logic       fast_boot;
		logic       program_mode;
		logic [2:0] cal_option;
		logic [4:0] target_mhz;
		logic [5:0] vdd_dv;
		logic [7:0] trim;
	} scb_boot_cfg_s;

	// Unlisted codes come back invalid and leave the running selection alone.
	function automatic scb_sel_s scb_decode_mode(input logic [7:0] mode);
		scb_sel_s sel;
		sel = '{valid: 1'b1, src: SCB_SRC_FAST, div_exp: 3'h0};
		unique case ({mode[7:5], mode[3]})
			4'b0010: sel.div_exp = 3'h1;
			4'b0000: sel.div_exp = 3'h2;
			4'b0011: sel.div_exp = 3'h3;
			4'b0001: sel.div_exp = 3'h4;
			4'b0111: sel.div_exp = 3'h5;
			4'b1110: sel.src = SCB_SRC_SLOW;
			4'b1010: sel.src = SCB_SRC_XTAL;
			default: sel.valid = 1'b0;
		endcase
		return sel;
	endfunction

	function automatic logic [7:0] scb_cal_mode(input logic [2:0] opt);
		logic [7:0] m;
		m = SCB_CLKMD_RST;
		unique case (opt)
			SCB_CAL_DIV2:  m = SCB_MODE_DIV2;
			SCB_CAL_DIV4:  m = SCB_MODE_DIV4;
			SCB_CAL_DIV8:  m = SCB_MODE_DIV8;
			SCB_CAL_DIV16: m = SCB_MODE_DIV16;
			SCB_CAL_DIV32: m = SCB_MODE_DIV32;
			SCB_CAL_SLOW:  m = SCB_MODE_SLOW;
			default:       m = SCB_CLKMD_RST;
		endcase
		return m;
	endfunction

endpackage

// ===== logic/scb_tick_sync.sv
// Turns a free running oscillator pin into a one-cycle tick on pclk.
// Assumes the oscillator runs well below half the pclk rate.
`timescale 1ns/10ps
`default_nettype none
module scb_tick_sync
(
	// Clock and reset
	input  wire logic pclk,
	input  wire logic presetn,
	// Oscillator pin and tick
	input  wire logic osc_pin,
	output logic      tick
);
	logic meta_reg;
	logic sync_reg;
	logic last_reg;

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			meta_reg <= 1'b0;
			sync_reg <= 1'b0;
			last_reg <= 1'b0;
		end
		else
		begin
			meta_reg <= osc_pin;
			sync_reg <= meta_reg;
			last_reg <= sync_reg;
		end
	end

	assign tick = sync_reg & ~last_reg;
endmodule
`default_nettype wire

// ===== logic/scb_clk_div.sv
// Source select and divider that produces the system clock enable.
// Assumes one tick per source cycle; the selected source must keep running.
`timescale 1ns/10ps
`default_nettype none
module scb_clk_div
	import scb_pkg::*;
(
	// Clock and reset
	input  wire logic      pclk,
	input  wire logic      presetn,
	// Sources
	input  wire logic [2:0] src_tick,
	input  wire logic [2:0] src_on,
	// Selection
	input  wire scb_sel_s   req,
	output scb_sel_s        active,
	output logic            clk_en
);
	logic [4:0] cnt_reg;
	logic [4:0] lim;
	logic       tick;
	logic       pulse;
	logic       switch_now;

	assign lim   = 5'((6'h01 << active.div_exp) - 6'h01);
	assign tick  = src_tick[active.src];
	assign pulse = tick && (cnt_reg == lim);
	// A change waits for the end of a whole divided period, so no pulse is cut short, unless the active source is off, when it goes at once.
	assign switch_now = req.valid && (req != active) &&
		(pulse || !src_on[active.src]);

	always_ff @(posedge pclk or negedge presetn)
	begin
		// Same selection as the clock mode reset value: slow RC, undivided.
		if (!presetn)
			active <= '{valid: 1'b1, src: SCB_SRC_SLOW, div_exp: 3'h0};
		else if (switch_now)
			active <= req;
	end

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			cnt_reg <= 5'h00;
		else if (switch_now)
			cnt_reg <= 5'h00;
		else if (tick)
			cnt_reg <= (cnt_reg == lim) ? 5'h00 : 5'(cnt_reg + 5'h01);
	end

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			clk_en <= 1'b0;
		else
			clk_en <= pulse;
	end

	property p_switch_at_boundary;
		@(posedge pclk) disable iff (!presetn)
		(active != $past(active)) |-> $past(pulse || !src_on[active.src]);
	endproperty
	a_switch_at_boundary: assert property (p_switch_at_boundary)
		else $error("clock selection changed inside a divided period");
endmodule
`default_nettype wire

// ===== logic/scb_clock_boot.sv
// System clock select, oscillator control, trim calibration and boot delay.
// Assumes an APB master on pclk, oscillator pins from the analog macros and the
// boot configuration word read from nonvolatile memory, stable after power-up.
`timescale 1ns/10ps
`default_nettype none
// Notes on behaviour
// - Crystal, fast RC and slow RC oscillators have their own enables: crystal bit 7, mode bits 4 and 2.
// - Software picks the system clock source and its divider through the clock mode register.
// - A trim register tunes the fast RC oscillator, normally to 16 MHz.
// - Mode 34h is fast RC over 2, 14h over 4 and 3Ch over 8.
// - Mode 1Ch is fast RC over 16, 7Ch over 32 and E4h is the slow RC undivided.
// - With calibration off, boot leaves mode and trim alone, calibrates nothing and keeps band-gap off.
// - After boot with a fast RC divider option, fast RC on, watchdog off, slow RC on, port A bit five input.
// - Calibration runs only during programming; later boots use the stored settings.
// - After reset, execution waits 45 slow RC cycles on fast boot or 3000 on normal boot.
// - Calibration accepts fast RC dividers of 2, 4, 8, 16 and 32.
// - Calibration accepts targets of 16 to 18 MHz and supplies of 1.8 to 5.5 volts.
module scb_clock_boot
	import scb_pkg::*;
(
	// APB slave
	input  wire logic        pclk,
	input  wire logic        presetn,
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [7:0]  paddr,
	input  wire logic [31:0] pwdata,
	output logic [31:0]      prdata,
	output logic             pready,
	output logic             pslverr,
	// Oscillator pins
	input  wire logic        fast_rc_oscillator,
	input  wire logic        slow_rc_oscillator,
	input  wire logic        crystal_oscillator,
	// Stored boot configuration
	input  wire scb_boot_cfg_s boot_cfg,
	// Oscillator control
	output logic             fast_rc_enable,
	output logic             slow_rc_enable,
	output logic             crystal_enable,
	output logic [1:0]       crystal_drive,
	output logic [7:0]       fast_rc_trim,
	// System state
	output logic             sys_clk_en,
	output logic             cpu_run,
	output logic             bandgap_enable,
	output logic             watchdog_enable,
	output logic             port_a_bit_five_input,
	// Calibration result for the programmer
	output logic [7:0]       cal_trim_result,
	output logic             cal_done
);
	// ****************************************************************
	// Declarations
	// ****************************************************************
	scb_boot_e     state_reg;
	scb_boot_cfg_s cfg_meta_reg;
	scb_boot_cfg_s cfg_reg;
	logic [7:0]    clkmd_reg;
	logic [7:0]    xtal_reg;
	logic [7:0]    trim_reg;
	logic [11:0]   boot_cnt_reg;
	logic [11:0]   boot_limit;
	logic [2:0]    cal_bit_reg;
	logic [7:0]    cal_trim_reg;
	logic [11:0]   win_cnt_reg;
	logic [11:0]   fast_cnt_reg;
	logic [11:0]   target_cnt;
	logic [4:0]    target_mhz;
	logic          cal_err_reg;
	logic          cal_wanted;
	logic          cal_range_ok;
	logic          opt_fast;
	logic          opt_apply;
	logic          win_end;
	logic [7:0]    cal_trial;
	logic [2:0]    ticks;
	logic [2:0]    osc_on;
	scb_sel_s      active;
	logic          wr;
	logic          rd_setup;
	logic          mapped;
	logic [31:0]   rd_data;

	// ****************************************************************
	// Oscillator ticks and clock divider
	// ****************************************************************
	scb_tick_sync u_sync [2:0] (
		.pclk    (pclk),
		.presetn (presetn),
		.osc_pin ({crystal_oscillator, slow_rc_oscillator, fast_rc_oscillator}),
		.tick    (ticks)
	);

	assign osc_on = {crystal_enable, slow_rc_enable, fast_rc_enable};

	scb_clk_div u_div (
		.pclk     (pclk),
		.presetn  (presetn),
		.src_tick (ticks),
		.src_on   (osc_on),
		.req      (scb_decode_mode(clkmd_reg)),
		.active   (active),
		.clk_en   (sys_clk_en)
	);

	// ****************************************************************
	// Boot configuration capture
	// ****************************************************************
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			cfg_meta_reg <= '0;
			cfg_reg      <= '0;
		end
		else
		begin
			cfg_meta_reg <= boot_cfg;
			if (state_reg == SCB_BOOT_DELAY)
				cfg_reg <= cfg_meta_reg;
		end
	end

	assign opt_fast   = (cfg_reg.cal_option <= SCB_CAL_DIV32);
	assign opt_apply  = opt_fast || (cfg_reg.cal_option == SCB_CAL_SLOW);
	assign target_mhz = (cfg_reg.target_mhz == 5'h00) ? SCB_TARGET_DEF_MHZ : cfg_reg.target_mhz;
	assign cal_range_ok = (target_mhz >= SCB_TARGET_MIN_MHZ) &&
		(target_mhz <= SCB_TARGET_MAX_MHZ) &&
		(cfg_reg.vdd_dv >= SCB_VDD_MIN_DV) && (cfg_reg.vdd_dv <= SCB_VDD_MAX_DV);
	assign cal_wanted = cfg_reg.program_mode && opt_apply;
	assign target_cnt = 12'(target_mhz * SCB_CAL_WINDOW_US);
	assign boot_limit = cfg_reg.fast_boot ? 12'(SCB_BOOT_FAST_CYC - 1) :
		12'(SCB_BOOT_NORMAL_CYC - 1);

	// ****************************************************************
	// Boot sequence
	// ****************************************************************
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			state_reg <= SCB_BOOT_DELAY;
		else
		begin
			unique case (state_reg)
				SCB_BOOT_DELAY:
					if (ticks[SCB_SRC_SLOW] && boot_cnt_reg == boot_limit)
						state_reg <= (cal_wanted && cal_range_ok) ? SCB_BOOT_CAL : SCB_BOOT_APPLY;
				SCB_BOOT_CAL:
					if (win_end && cal_bit_reg == 3'h0)
						state_reg <= SCB_BOOT_APPLY;
				SCB_BOOT_APPLY:
					state_reg <= SCB_BOOT_RUN;
				SCB_BOOT_RUN:
					state_reg <= SCB_BOOT_RUN;
			endcase
		end
	end

	// Counts slow RC ticks, so the delay follows that oscillator's own drift.
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			boot_cnt_reg <= 12'h000;
		else if (state_reg == SCB_BOOT_DELAY && ticks[SCB_SRC_SLOW])
			boot_cnt_reg <= 12'(boot_cnt_reg + 12'h001);
	end

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			cal_err_reg <= 1'b0;
		else if (state_reg == SCB_BOOT_DELAY && ticks[SCB_SRC_SLOW] &&
			boot_cnt_reg == boot_limit && cal_wanted && !cal_range_ok)
			cal_err_reg <= 1'b1;
	end

	// ****************************************************************
	// Trim search
	// ****************************************************************
	// Successive approximation, one bit per window; a higher trim runs faster.
	assign cal_trial = cal_trim_reg | 8'(8'h01 << cal_bit_reg);
	assign win_end   = (win_cnt_reg == 12'(SCB_CAL_WINDOW_CYC - 1));

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			win_cnt_reg  <= 12'h000;
			fast_cnt_reg <= 12'h000;
			cal_bit_reg  <= 3'h7;
			cal_trim_reg <= 8'h00;
		end
		else if (state_reg == SCB_BOOT_CAL)
		begin
			if (win_end)
			begin
				win_cnt_reg  <= 12'h000;
				fast_cnt_reg <= 12'h000;
				cal_bit_reg  <= 3'(cal_bit_reg - 3'h1);
				if (fast_cnt_reg < target_cnt)
					cal_trim_reg <= cal_trial;
			end
			else
			begin
				win_cnt_reg <= 12'(win_cnt_reg + 12'h001);
				if (ticks[SCB_SRC_FAST])
					fast_cnt_reg <= 12'(fast_cnt_reg + 12'h001);
			end
		end
	end

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			cal_done <= 1'b0;
		else if (state_reg == SCB_BOOT_CAL && win_end && cal_bit_reg == 3'h0)
			cal_done <= 1'b1;
	end

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			cal_trim_result <= 8'h00;
		else if (state_reg == SCB_BOOT_APPLY && cal_done)
			cal_trim_result <= cal_trim_reg;
	end

	// ****************************************************************
	// Clock mode, crystal and trim registers
	// ****************************************************************
	assign wr       = psel && penable && pwrite;
	assign rd_setup = psel && !penable && !pwrite;

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			clkmd_reg <= SCB_CLKMD_RST;
			trim_reg  <= SCB_TRIM_RST;
		end
		else if (state_reg == SCB_BOOT_APPLY)
		begin
			if (opt_apply)
			begin
				clkmd_reg <= scb_cal_mode(cfg_reg.cal_option);
				trim_reg  <= cal_done ? cal_trim_reg : cfg_reg.trim;
			end
		end
		else
		begin
			if (wr && paddr == SCB_ADDR_CLKMD)
				clkmd_reg <= pwdata[7:0];
			if (wr && paddr == SCB_ADDR_TRIM)
				trim_reg <= pwdata[7:0];
		end
	end

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			xtal_reg <= SCB_XTAL_RST;
		else if (wr && paddr == SCB_ADDR_XTAL)
			xtal_reg <= pwdata[7:0];
	end

	// ****************************************************************
	// Oscillator and system outputs
	// ****************************************************************
	assign crystal_enable = xtal_reg[SCB_XTAL_EN];
	assign crystal_drive  = xtal_reg[SCB_XTAL_DRV_LSB +: 2];

	// The fast oscillator is forced on while its trim is being searched.
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			fast_rc_enable <= 1'b0;
			slow_rc_enable <= 1'b0;
			fast_rc_trim   <= SCB_TRIM_RST;
		end
		else
		begin
			fast_rc_enable <= clkmd_reg[SCB_CLKMD_FAST_EN] || (state_reg == SCB_BOOT_CAL);
			slow_rc_enable <= clkmd_reg[SCB_CLKMD_SLOW_EN];
			fast_rc_trim   <= (state_reg == SCB_BOOT_CAL) ? cal_trial : trim_reg;
		end
	end

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			bandgap_enable        <= 1'b0;
			watchdog_enable       <= 1'b1;
			port_a_bit_five_input <= 1'b0;
			cpu_run               <= 1'b0;
		end
		else if (state_reg == SCB_BOOT_APPLY)
		begin
			bandgap_enable        <= opt_apply;
			watchdog_enable       <= !opt_apply;
			port_a_bit_five_input <= 1'b1;
			cpu_run               <= 1'b1;
		end
	end

	// ****************************************************************
	// APB read path
	// ****************************************************************
	assign mapped = (paddr == SCB_ADDR_CLKMD) || (paddr == SCB_ADDR_XTAL) ||
		(paddr == SCB_ADDR_TRIM) || (paddr == SCB_ADDR_STATUS) ||
		(paddr == SCB_ADDR_CALRES);

	always_comb
	begin
		rd_data = 32'h0000_0000;
		unique case (paddr)
			SCB_ADDR_CLKMD:  rd_data[7:0] = clkmd_reg;
			SCB_ADDR_XTAL:   rd_data[7:0] = xtal_reg;
			SCB_ADDR_TRIM:   rd_data[7:0] = trim_reg;
			SCB_ADDR_STATUS:
			begin
				rd_data[SCB_ST_RUN]      = cpu_run;
				rd_data[SCB_ST_CAL_BUSY] = (state_reg == SCB_BOOT_CAL);
				rd_data[SCB_ST_CAL_DONE] = cal_done;
				rd_data[SCB_ST_CAL_ERR]  = cal_err_reg;
				rd_data[SCB_ST_SRC_LSB +: 2] = active.src;
				rd_data[SCB_ST_DIV_LSB +: 3] = active.div_exp;
			end
			SCB_ADDR_CALRES: rd_data[7:0] = cal_trim_result;
			default:         rd_data = 32'h0000_0000;
		endcase
	end

	// Read data is taken in the setup cycle so the access phase needs no wait.
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			prdata <= 32'h0000_0000;
		else if (rd_setup)
			prdata <= rd_data;
	end

	assign pready  = 1'b1;
	assign pslverr = psel && penable && !mapped;

	// ****************************************************************
	// Checks
	// ****************************************************************
	property p_hold_in_delay;
		@(posedge pclk) disable iff (!presetn)
		(state_reg == SCB_BOOT_DELAY) |-> !cpu_run;
	endproperty
	a_hold_in_delay: assert property (p_hold_in_delay)
		else $error("cpu running during boot delay");

	property p_delay_ends;
		@(posedge pclk) disable iff (!presetn)
		(state_reg == SCB_BOOT_DELAY && ticks[SCB_SRC_SLOW] && boot_cnt_reg == boot_limit)
		|=> (state_reg != SCB_BOOT_DELAY);
	endproperty
	a_delay_ends: assert property (p_delay_ends)
		else $error("boot delay overran its count");

	property p_apply_mode;
		@(posedge pclk) disable iff (!presetn)
		(state_reg == SCB_BOOT_APPLY && cfg_reg.cal_option == SCB_CAL_SLOW)
		|=> (clkmd_reg == SCB_MODE_SLOW);
	endproperty
	a_apply_mode: assert property (p_apply_mode)
		else $error("slow option left wrong clock mode");

	property p_div2_value;
		@(posedge pclk) disable iff (!presetn)
		(state_reg == SCB_BOOT_APPLY && cfg_reg.cal_option == SCB_CAL_DIV2)
		|=> (clkmd_reg == SCB_MODE_DIV2) ##1 (fast_rc_enable && slow_rc_enable);
	endproperty
	a_div2_value: assert property (p_div2_value)
		else $error("divide by two option left wrong mode");

	property p_off_untouched;
		@(posedge pclk) disable iff (!presetn)
		(state_reg == SCB_BOOT_APPLY && !opt_apply)
		|=> $stable(clkmd_reg) && $stable(trim_reg) && !bandgap_enable && watchdog_enable;
	endproperty
	a_off_untouched: assert property (p_off_untouched)
		else $error("disabled calibration changed clock state");

	property p_fast_option_state;
		@(posedge pclk) disable iff (!presetn)
		(state_reg == SCB_BOOT_APPLY && opt_fast)
		|=> ##1 (fast_rc_enable && slow_rc_enable && !watchdog_enable && port_a_bit_five_input);
	endproperty
	a_fast_option_state: assert property (p_fast_option_state)
		else $error("wrong state after fast divider boot");

	property p_cal_only_programming;
		@(posedge pclk) disable iff (!presetn)
		(state_reg == SCB_BOOT_CAL) |-> (cfg_reg.program_mode && cal_range_ok);
	endproperty
	a_cal_only_programming: assert property (p_cal_only_programming)
		else $error("calibration ran outside programming");

	property p_crystal_write;
		@(posedge pclk) disable iff (!presetn)
		(wr && paddr == SCB_ADDR_XTAL) |=> (crystal_enable == $past(pwdata[7]));
	endproperty
	a_crystal_write: assert property (p_crystal_write)
		else $error("crystal enable did not follow write");

	property p_trim_write;
		@(posedge pclk) disable iff (!presetn)
		(wr && paddr == SCB_ADDR_TRIM && state_reg == SCB_BOOT_RUN)
		|=> ##1 (fast_rc_trim == $past(pwdata[7:0], 2));
	endproperty
	a_trim_write: assert property (p_trim_write)
		else $error("trim output did not follow write");
endmodule
`default_nettype wire

// ===== verification/tb_system_clock_select_boot.sv
// Self-checking bench for the system clock select and boot block.
// Assumes scb_pkg and the design files are compiled before this file.
`timescale 1ns/10ps
`default_nettype none
`define CHK(nm, e, g) begin n_checks++; if ((g) !== (e)) begin n_mismatch++; \
	$display("MISMATCH %s exp %0h got %0h", nm, e, g); end end
module tb_system_clock_select_boot;
	import scb_pkg::*;
	logic          pclk = 1'b0;
	logic          presetn = 1'b0;
	logic          psel = 1'b0;
	logic          penable = 1'b0;
	logic          pwrite = 1'b0;
	logic [7:0]    paddr = 8'h00;
	logic [31:0]   pwdata = 32'h0;
	logic          fast_rc_oscillator = 1'b0;
	logic          slow_rc_oscillator = 1'b0;
	logic          crystal_oscillator = 1'b0;
	scb_boot_cfg_s boot_cfg = '0;
	logic [31:0]   prdata;
	logic          pready, pslverr, fast_rc_enable, slow_rc_enable, crystal_enable;
	logic [7:0]    fast_rc_trim, trim_v, cal_trim_result;
	logic [1:0]    crystal_drive;
	logic          sys_clk_en, cpu_run, bandgap_enable, watchdog_enable;
	logic          port_a_bit_five_input, cal_done;
	int            n_checks = 0;
	int            n_mismatch = 0;
	logic [7:0]    md [7] = '{8'h34, 8'h14, 8'h3c, 8'h1c, 8'h7c, 8'he4, 8'hf4};
	logic [7:0]    codes [8] = '{8'h34, 8'h14, 8'h3c, 8'h1c, 8'h7c, 8'hb0, 8'hf4, 8'he4};
	int            pers [8] = '{8, 16, 32, 64, 128, 12, 8, 8};

	// Sources run free at 4, 8 and 12 pclk periods, out of phase with pclk.
	always #12.5 pclk = ~pclk;
	always #50 fast_rc_oscillator = ~fast_rc_oscillator;
	always #100 slow_rc_oscillator = ~slow_rc_oscillator;
	always #150 crystal_oscillator = ~crystal_oscillator;

	scb_clock_boot dut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
		.pready, .pslverr, .fast_rc_oscillator, .slow_rc_oscillator, .crystal_oscillator,
		.boot_cfg, .fast_rc_enable, .slow_rc_enable, .crystal_enable, .crystal_drive,
		.fast_rc_trim, .sys_clk_en, .cpu_run, .bandgap_enable, .watchdog_enable,
		.port_a_bit_five_input, .cal_trim_result, .cal_done);

	task automatic apb(input logic w, input logic [7:0] a, input logic [7:0] d,
		output logic [31:0] r, output logic e);
		@(posedge pclk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= a;
		pwdata <= {24'h0, d};
		@(posedge pclk);
		penable <= 1'b1;
		do @(posedge pclk); while (pready !== 1'b1);
		r = prdata;
		e = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask

	// The first pulses after a switch may belong to the old selection, so only the last gap counts.
	task automatic measure(output int p);
		int k;
		k = 0;
		repeat (4)
		begin
			p = 0;
			do begin @(negedge pclk); p++; k++; end while (sys_clk_en !== 1'b1 && k < 2000);
		end
	endtask

	task automatic boot(input logic fb, input logic pm, input logic [2:0] op, input int n);
		int         c;
		logic [31:0] r;
		logic       e;
		c = 0;
		@(posedge pclk);
		presetn <= 1'b0;
		boot_cfg <= '{fb, pm, op, 5'h10, 6'h32, trim_v};
		repeat (16) @(posedge pclk);
		presetn <= 1'b1;
		while (cpu_run !== 1'b1 && c < 70000) begin @(negedge pclk); c++; end
		// One more cycle lets the oscillator enables follow the applied mode.
		@(negedge pclk);
		`CHK("boot_done", 1'b1, cpu_run)
		if (!pm)
			`CHK("boot_delay", 1'b1, (c >= n * 8 - 8 && c <= n * 8 + 40))
		`CHK("watchdog", (op == SCB_CAL_OFF), watchdog_enable)
		`CHK("bandgap", (op != SCB_CAL_OFF), bandgap_enable)
		`CHK("pa5_in", 1'b1, port_a_bit_five_input)
		`CHK("rc_en", {md[op][4], md[op][2]}, {fast_rc_enable, slow_rc_enable})
		`CHK("cal_done", (pm && op != SCB_CAL_OFF), cal_done)
		// The bench's fast source runs below any legal target, so the search keeps every bit.
		`CHK("cal_result", pm ? 8'hff : 8'h00, cal_trim_result)
		apb(1'b0, SCB_ADDR_CLKMD, 8'h00, r, e);
		`CHK("clkmd_boot", {24'h0, md[op]}, r)
		apb(1'b0, SCB_ADDR_TRIM, 8'h00, r, e);
		`CHK("trim_boot", {24'h0, (op == SCB_CAL_OFF) ? 8'h80 : (pm ? 8'hff : trim_v)}, r)
		$display("test boot option %0d done", op);
	endtask

	task automatic give_verdict;
		$display("checks %0d mismatches %0d", n_checks, n_mismatch);
		if (n_mismatch == 0 && n_checks > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask

	initial
	begin
		#2000000;
		n_mismatch++;
		give_verdict();
	end

	initial
	begin
		logic [31:0] r;
		logic        e;
		int          p;
		void'($urandom(28062));
		trim_v = 8'($urandom);
		boot(1'b1, 1'b0, SCB_CAL_OFF, 45);
		apb(1'b0, SCB_ADDR_XTAL, 8'h00, r, e);
		`CHK("xtal_rst", 32'h0, r)
		apb(1'b1, SCB_ADDR_XTAL, 8'he0, r, e);
		@(negedge pclk);
		`CHK("xtal_en", 1'b1, crystal_enable)
		`CHK("xtal_drv", 2'b11, crystal_drive)
		apb(1'b0, 8'h20, 8'h00, r, e);
		`CHK("unmapped_err", 1'b1, e)
		apb(1'b1, SCB_ADDR_TRIM, ~trim_v, r, e);
		apb(1'b0, SCB_ADDR_TRIM, 8'h00, r, e);
		`CHK("trim_rd", {24'h0, ~trim_v}, r)
		`CHK("trim_out", ~trim_v, fast_rc_trim)
		for (int i = 0; i < 8; i++)
		begin
			// Every switching write keeps the old source enabled.
			apb(1'b1, SCB_ADDR_CLKMD, codes[i], r, e);
			apb(1'b0, SCB_ADDR_CLKMD, 8'h00, r, e);
			`CHK("clkmd", {24'h0, codes[i]}, r)
			`CHK("osc_en", {codes[i][4], codes[i][2]}, {fast_rc_enable, slow_rc_enable})
			measure(p);
			`CHK("period", pers[i], p)
		end
		$display("test clock modes done");
		// Every divider and the slow option once, on fast boot to keep the run short.
		for (int o = 0; o < 6; o++)
			boot(1'b1, 1'b0, 3'(o), 45);
		boot(1'b0, 1'b0, SCB_CAL_DIV4, 3000);
		boot(1'b1, 1'b1, SCB_CAL_DIV8, 45);
		give_verdict();
	end
endmodule
`default_nettype wire
